//--- aswc_assertions.sv
// Port checker of the auto-sleep controller
`include "aswc_cfg.svh"
`default_nettype none
module aswc_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register port
	input wire aswc_pkg::aswc_byte_t reg_addr,
	input wire aswc_pkg::aswc_byte_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire aswc_pkg::aswc_byte_t reg_rdata,
	// Events
	input wire logic [`ASWC_EV_W-1:0] event_flags,
	// Mode outputs
	input wire logic asleep,
	input wire aswc_pkg::aswc_rate_t active_rate_select,
	input wire logic [1:0] sleep_rate_select,
	input wire logic sleep_irq,
	input wire logic fifo_func_on,
	input wire logic drdy_func_on
);
	import aswc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Mode register read strobe
	wire logic rd_mode = reg_rd && reg_addr == `ASWC_ADDR_SYSMODE;

	a_rate_copy:
	assert property (reg_wr && reg_addr == `ASWC_ADDR_CTRL1 |=> ##1 active_rate_select == $past(reg_wdata[5:3], 2)
		&& sleep_rate_select == $past(reg_wdata[7:6], 2)) else $error("rate outputs off");
	a_mode_read:
	assert property ($past(rd_mode) |-> reg_rdata[6:0] == {5'h00, ($past(asleep) ? 2'h2 : 2'h1)})
		else $error("mode read wrong");
	a_rdata_idle:
	assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
	a_irq_clear:
	assert property (rd_mode ##1 $stable(asleep) |=> ##[0:1] !sleep_irq) else $error("irq not cleared");
	a_irq_cause:
	assert property ($rose(sleep_irq) |-> $past(asleep) != $past(asleep, 2)) else $error("irq without change");
	a_irq_hold:
	assert property (sleep_irq && !reg_rd && !$past(reg_rd) && !$past(reg_wr) |=> sleep_irq) else $error("irq lost");
	a_wake_cause:
	assert property ($fell(asleep) |-> $past(|(event_flags & `ASWC_WAKE_MASK))) else $error("wake without event");
	a_funcs_off:
	assert property (asleep && $past(asleep) |-> !fifo_func_on && !drdy_func_on) else $error("function on in sleep");
endmodule
bind aswc_top aswc_assertions u_chk (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.event_flags, .asleep, .active_rate_select, .sleep_rate_select, .sleep_irq, .fifo_func_on, .drdy_func_on);
`default_nettype wire

//--- aswc_cfg.svh
// Offsets, field positions, reset values and timing figures of the auto-sleep controller
`ifndef ASWC_CFG_SVH
`define ASWC_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ASWC_ADDR_SYSMODE 8'h0b
`define ASWC_ADDR_INACT 8'h29
`define ASWC_ADDR_CTRL1 8'h2a
`define ASWC_ADDR_CTRL2 8'h2b
`define ASWC_ADDR_WAKE 8'h2c
`define ASWC_ADDR_INTEN 8'h2d

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ASWC_RST_INACT 8'h00
`define ASWC_RST_CTRL 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ASWC_C1_SLEEP_RATE_HI 7
`define ASWC_C1_SLEEP_RATE_LO 6
`define ASWC_C1_ACT_RATE_HI 5
`define ASWC_C1_ACT_RATE_LO 3
`define ASWC_C2_SLEEP_EN 2
`define ASWC_WK_FIFO_GATE 7
`define ASWC_WK_TRANS 6
`define ASWC_WK_ORIENT 5
`define ASWC_WK_TAP 4
`define ASWC_WK_FALL 3
`define ASWC_WK_AMAG 2
`define ASWC_WK_FIELD 1
`define ASWC_IE_SLEEP 7
`define ASWC_IE_FIFO 6
`define ASWC_IE_TRANS 5
`define ASWC_IE_ORIENT 4
`define ASWC_IE_TAP 3
`define ASWC_IE_FALL 2
`define ASWC_IE_AMAG 1
`define ASWC_IE_DRDY 0
`define ASWC_SM_FGERR 7

// ----------------------------------------
// Event vector positions and masks
// ----------------------------------------
`define ASWC_EV_FIFO 0
`define ASWC_EV_TRANS 1
`define ASWC_EV_ORIENT 2
`define ASWC_EV_TAP 3
`define ASWC_EV_FALL 4
`define ASWC_EV_SLEEP 5
`define ASWC_EV_FIELD 6
`define ASWC_EV_DRDY 7
`define ASWC_EV_AMAG 8
`define ASWC_EV_FMAG 9
`define ASWC_EV_FTHR 10
`define ASWC_EV_W 11
`define ASWC_RESTART_MASK 11'h75f
`define ASWC_WAKE_MASK 11'h75e

// ----------------------------------------
// Mode codes and timing
// ----------------------------------------
`define ASWC_MODE_WAKE 2'h1
`define ASWC_MODE_SLEEP 2'h2
`define ASWC_STEP_MS 320
`define ASWC_STEP_SLOW_MS 640
// Samples per step: 320 ms worth of samples at the rate of each code, except one 640 ms sample at the slowest code
`define ASWC_STEP_800 9'h100
`define ASWC_STEP_400 9'h080
`define ASWC_STEP_200 9'h040
`define ASWC_STEP_100 9'h020
`define ASWC_STEP_50 9'h010
`define ASWC_STEP_12 9'h004
`define ASWC_STEP_6 9'h002
`define ASWC_STEP_1 9'h001

`endif

//--- aswc_pkg.sv
// Types of the auto-sleep controller
`default_nettype none
package aswc_pkg;
	typedef enum logic {
		ASWC_AWAKE,
		ASWC_ASLEEP
	} aswc_state_t;
	typedef logic [2:0] aswc_rate_t;
	typedef logic [7:0] aswc_byte_t;
endpackage
`default_nettype wire

//--- aswc_step_if.sv
// Carrier between the controller and its inactivity step timer
`default_nettype none
interface aswc_step_if;
	import aswc_pkg::*;
	logic sample_tick;
	aswc_rate_t rate_code;
	logic hybrid;
	logic clear;
	logic step_tick;
	modport timer (input sample_tick, input rate_code, input hybrid, input clear, output step_tick);
	modport ctrl (output sample_tick, output rate_code, output hybrid, output clear, input step_tick);
endinterface
`default_nettype wire

//--- aswc_step_timer.sv
// Inactivity step timer: turns output-data-rate samples into count steps
`include "aswc_cfg.svh"
`default_nettype none
module aswc_step_timer #(
	parameter int SAMPLE_W = 9
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Controller side
	aswc_step_if.timer st
);
	import aswc_pkg::*;

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (SAMPLE_W < 9) begin : g_chk
		$error("aswc_step_timer: SAMPLE_W must be at least 9");
	end

	// Samples per step for a rate code; 1.56 Hz gives a 640 ms step
	function automatic logic [8:0] step_len(input aswc_rate_t code);
		case (code)
			3'h0: step_len = `ASWC_STEP_800; // R02
			3'h1: step_len = `ASWC_STEP_400;
			3'h2: step_len = `ASWC_STEP_200;
			3'h3: step_len = `ASWC_STEP_100;
			3'h4: step_len = `ASWC_STEP_50;
			3'h5: step_len = `ASWC_STEP_12;
			3'h6: step_len = `ASWC_STEP_6;
			default: step_len = `ASWC_STEP_1;
		endcase
	endfunction

	logic [SAMPLE_W-1:0] samples;
	logic phase;
	logic step_tick;
	wire logic eff_tick;
	wire logic [SAMPLE_W-1:0] limit;
	wire logic last;

	// Hybrid mode halves the effective rate: only every second sample counts
	assign eff_tick = st.sample_tick & (~st.hybrid | phase); // R03
	assign limit = SAMPLE_W'(step_len(st.rate_code));
	assign last = eff_tick & (samples >= limit - SAMPLE_W'(1));
	assign st.step_tick = step_tick;

	// Alternation phase for hybrid sampling
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phase <= 1'b0;
		end else if (st.clear) begin
			phase <= 1'b0;
		end else if (st.sample_tick) begin
			phase <= ~phase;
		end
	end

	// Sample counter and step pulse
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			samples <= '0;
			step_tick <= 1'b0;
		end else begin
			step_tick <= last & ~st.clear;
			if (st.clear || last) begin
				samples <= '0;
			end else if (eff_tick) begin
				samples <= samples + SAMPLE_W'(1);
			end
		end
	end
endmodule
`default_nettype wire

//--- aswc_top.sv
// Auto-sleep and wake controller with its register set
`include "aswc_cfg.svh"
`default_nettype none

// Overview of operation
// [R01] Drop to sleep rate after programmed inactivity, only while sleep enable is 1.
// [R02] Count step is 320 ms, or 640 ms at the slowest rate.
// [R03] Hybrid mode steps on half the selected active rate.
// [R04] Listed events restart the timer; sleep and ready do not; buffer cannot wake.
// [R05] A restart event before the count is reached clears the sleep counter.
// [R06] No restart event until the count elapses: enter sleep, use sleep rate.
// [R07] An enabled wake event during sleep returns to the active rate.
// [R08] Events act only when their own function is enabled.
// [R09] Bypassed flags suspended in sleep, resumed on wake; data-ready stays off.
// [R10] Each transition raises the sleep interrupt; reading system mode clears it. Code raises it only while sleep interrupt enable is 1.
// [R11] With buffer gate set, sleep entry keeps buffer, flags gate error, blocks samples.
// [R12] With gate set, a pending sleep interrupt blocks the buffer, not transitions.
// [R13] Sleep interrupt enable gates the transition interrupt onto its output.
// [R14] Inactivity counter held clear while sleep enable is 0.
module aswc_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register access from the serial port
	input wire aswc_pkg::aswc_byte_t reg_addr,
	input wire aswc_pkg::aswc_byte_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output aswc_pkg::aswc_byte_t reg_rdata,
	// Sampling and event sources
	input wire logic sample_tick,
	input wire logic hybrid_mode,
	input wire logic [`ASWC_EV_W-1:0] event_flags,
	input wire logic [2:0] field_func_en,
	input wire logic fifo_empty,
	// Mode and gating outputs
	output logic asleep,
	output aswc_pkg::aswc_rate_t active_rate_select,
	output logic [1:0] sleep_rate_select,
	output logic sleep_irq,
	output logic fifo_block,
	output logic fifo_func_on,
	output logic drdy_func_on
);
	import aswc_pkg::*;

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	aswc_byte_t inactivity_count;
	aswc_byte_t control_one;
	aswc_byte_t control_two;
	aswc_byte_t wake_enable_reg;
	aswc_byte_t int_enable;
	aswc_byte_t inact_cnt;
	aswc_state_t state;
	aswc_state_t next_state;
	logic sleep_pending;
	logic fgerr;
	logic drdy_held;
	aswc_step_if st ();

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire logic wr_inact = reg_wr & (reg_addr == `ASWC_ADDR_INACT);
	wire logic wr_ctrl1 = reg_wr & (reg_addr == `ASWC_ADDR_CTRL1);
	wire logic wr_ctrl2 = reg_wr & (reg_addr == `ASWC_ADDR_CTRL2);
	wire logic wr_wake = reg_wr & (reg_addr == `ASWC_ADDR_WAKE);
	wire logic wr_inten = reg_wr & (reg_addr == `ASWC_ADDR_INTEN);
	wire logic rd_sysmode = reg_rd & (reg_addr == `ASWC_ADDR_SYSMODE);
	wire logic sleep_en = control_two[`ASWC_C2_SLEEP_EN];
	wire logic fifo_gate = wake_enable_reg[`ASWC_WK_FIFO_GATE];
	wire logic is_asleep = (state == ASWC_ASLEEP);

	// Function enables per event source
	wire logic [`ASWC_EV_W-1:0] func_en = {
		field_func_en[2], field_func_en[1], int_enable[`ASWC_IE_AMAG],
		int_enable[`ASWC_IE_DRDY], field_func_en[0], 1'b0,
		int_enable[`ASWC_IE_FALL], int_enable[`ASWC_IE_TAP], int_enable[`ASWC_IE_ORIENT],
		int_enable[`ASWC_IE_TRANS], int_enable[`ASWC_IE_FIFO]};
	// Wake enables per event source
	wire logic [`ASWC_EV_W-1:0] wake_en = {
		wake_enable_reg[`ASWC_WK_FIELD], wake_enable_reg[`ASWC_WK_FIELD], wake_enable_reg[`ASWC_WK_AMAG],
		1'b0, wake_enable_reg[`ASWC_WK_FIELD], 1'b0,
		wake_enable_reg[`ASWC_WK_FALL], wake_enable_reg[`ASWC_WK_TAP], wake_enable_reg[`ASWC_WK_ORIENT],
		wake_enable_reg[`ASWC_WK_TRANS], 1'b0};

	// Restart and wake qualification
	wire logic [`ASWC_EV_W-1:0] live = event_flags & func_en; // R08
	wire logic restart = |(live & `ASWC_RESTART_MASK); // R04
	wire logic wake = |(live & wake_en & `ASWC_WAKE_MASK); // R04 R07
	wire logic count_clear = ~sleep_en | restart | is_asleep; // R05 R14
	wire logic count_done = (inact_cnt >= inactivity_count) & ~restart; // R06
	wire logic enter_sleep = ~is_asleep & sleep_en & count_done; // R01 R06
	wire logic leave_sleep = is_asleep & wake; // R07
	wire logic transition = enter_sleep | leave_sleep;

	// Step timer hookup
	assign st.sample_tick = sample_tick;
	assign st.rate_code = control_one[`ASWC_C1_ACT_RATE_HI:`ASWC_C1_ACT_RATE_LO];
	assign st.hybrid = hybrid_mode; // R03
	assign st.clear = count_clear;

	aswc_step_timer #(
		.SAMPLE_W(9)
	) u_step (
		.clk(clk),
		.rst_b(rst_b),
		.st(st.timer)
	);

	// Next mode
	always_comb begin
		next_state = state;
		case (state)
			ASWC_AWAKE: begin
				if (enter_sleep) begin
					next_state = ASWC_ASLEEP;
				end
			end
			ASWC_ASLEEP: begin
				if (leave_sleep) begin
					next_state = ASWC_AWAKE;
				end
			end
			default: next_state = ASWC_AWAKE;
		endcase
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			inactivity_count <= `ASWC_RST_INACT;
			control_one <= `ASWC_RST_CTRL;
			control_two <= `ASWC_RST_CTRL;
			wake_enable_reg <= `ASWC_RST_CTRL;
			int_enable <= `ASWC_RST_CTRL;
		end else begin
			if (wr_inact) inactivity_count <= reg_wdata;
			if (wr_ctrl1) control_one <= reg_wdata;
			if (wr_ctrl2) control_two <= reg_wdata;
			if (wr_wake) wake_enable_reg <= reg_wdata;
			if (wr_inten) int_enable <= reg_wdata;
		end
	end

	// Mode and inactivity counter
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ASWC_AWAKE;
			inact_cnt <= 8'h00;
		end else begin
			state <= next_state;
			if (count_clear) begin
				inact_cnt <= 8'h00; // R05 R14
			end else if (st.step_tick && inact_cnt != 8'hff) begin
				inact_cnt <= inact_cnt + 8'h01; // R02
			end
		end
	end

	// Transition flag: a new transition wins over a clearing read
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sleep_pending <= 1'b0;
		end else if (transition && int_enable[`ASWC_IE_SLEEP]) begin
			sleep_pending <= 1'b1; // R10
		end else if (rd_sysmode) begin
			sleep_pending <= 1'b0; // R10
		end
	end

	// Gate error and held-off data-ready
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fgerr <= 1'b0;
			drdy_held <= 1'b0;
		end else begin
			if (enter_sleep && fifo_gate) begin
				fgerr <= 1'b1; // R11
			end else if (fifo_empty) begin
				fgerr <= 1'b0;
			end
			if (enter_sleep && int_enable[`ASWC_IE_DRDY]) begin
				drdy_held <= 1'b1; // R09
			end else if (wr_inten) begin
				drdy_held <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
			asleep <= 1'b0;
			active_rate_select <= 3'h0;
			sleep_rate_select <= 2'h0;
			sleep_irq <= 1'b0;
			fifo_block <= 1'b0;
			fifo_func_on <= 1'b0;
			drdy_func_on <= 1'b0;
		end else begin
			reg_rdata <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
					`ASWC_ADDR_SYSMODE: reg_rdata <= {fgerr, 5'h00, is_asleep ? `ASWC_MODE_SLEEP : `ASWC_MODE_WAKE};
					`ASWC_ADDR_INACT: reg_rdata <= inactivity_count;
					`ASWC_ADDR_CTRL1: reg_rdata <= control_one;
					`ASWC_ADDR_CTRL2: reg_rdata <= control_two;
					`ASWC_ADDR_WAKE: reg_rdata <= wake_enable_reg;
					`ASWC_ADDR_INTEN: reg_rdata <= int_enable;
					default: reg_rdata <= 8'h00;
				endcase
			end
			asleep <= (next_state == ASWC_ASLEEP); // R06 R07
			active_rate_select <= control_one[`ASWC_C1_ACT_RATE_HI:`ASWC_C1_ACT_RATE_LO];
			sleep_rate_select <= control_one[`ASWC_C1_SLEEP_RATE_HI:`ASWC_C1_SLEEP_RATE_LO];
			sleep_irq <= sleep_pending & int_enable[`ASWC_IE_SLEEP]; // R13
			fifo_block <= fgerr | (fifo_gate & sleep_pending); // R11 R12
			fifo_func_on <= int_enable[`ASWC_IE_FIFO] & (next_state == ASWC_AWAKE); // R09
			drdy_func_on <= int_enable[`ASWC_IE_DRDY] & ~drdy_held & (next_state == ASWC_AWAKE); // R09
		end
	end
endmodule
`default_nettype wire

//--- aswc_top_test.sv
// Self-checking bench of the auto-sleep controller
`include "aswc_cfg.svh"
`default_nettype none
module aswc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import aswc_pkg::*;
	// Stimulus and observed signals
	logic clk = 1'h0, rst_b = 1'h0;
	aswc_byte_t reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic reg_wr = 1'h0, reg_rd = 1'h0, sample_tick = 1'h0, hybrid_mode = 1'h0, fifo_empty = 1'h0;
	logic [`ASWC_EV_W-1:0] event_flags = '0;
	logic [2:0] field_func_en = 3'h0;
	logic asleep, sleep_irq, fifo_block, fifo_func_on, drdy_func_on;
	aswc_rate_t active_rate_select;
	logic [1:0] sleep_rate_select;
	int errors = 0, compares = 0;
	// Clock
	always #2.5 clk = ~clk;
	aswc_top dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_tick,
		.hybrid_mode, .event_flags, .field_func_en, .fifo_empty, .asleep, .active_rate_select,
		.sleep_rate_select, .sleep_irq, .fifo_block, .fifo_func_on, .drdy_func_on);
	// ----------------
	// Tasks
	// ----------------
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(aswc_byte_t a, aswc_byte_t d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		step(1);
		reg_wr = 1'h0;
		step(1);
	endtask
	task automatic rd(aswc_byte_t a, aswc_byte_t e);
		reg_addr = a;
		reg_rd = 1'h1;
		step(1);
		reg_rd = 1'h0;
		chk(reg_rdata, e);
		step(1);
	endtask
	task automatic tick(int n);
		repeat (n) begin
			sample_tick = 1'h1;
			step(1);
			sample_tick = 1'h0;
			step(1);
		end
	endtask
	task automatic pulse(logic [`ASWC_EV_W-1:0] ev);
		event_flags ^= ev;
		step(1);
		event_flags ^= ev;
		step(1);
	endtask
	task automatic sleep_at(aswc_rate_t c, logic h, int n);
		wr(`ASWC_ADDR_CTRL1, {2'h1, c, 3'h0});
		hybrid_mode = h;
		pulse(11'h002);
		tick(n - 1);
		step(4);
		chk(asleep, 8'h00);
		chk(fifo_block, 8'h01);
		tick(1);
		step(4);
		chk(asleep, 8'h01);
	endtask
	task automatic conclude;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog
	initial begin
		#100us;
		errors++;
		conclude;
	end
	// ----------------
	// Tests
	// ----------------
	initial begin
		step(4);
		rst_b = 1'h1;
		step(1);
		rd(8'h29, 8'h00);
		rd(8'h0b, 8'h01);
		rd(8'h30, 8'h00);
		wr(8'h0b, 8'hff);
		rd(8'h0b, 8'h01);
		$display("test reset done");
		wr(8'h29, 8'h02);
		rd(8'h29, 8'h02);
		wr(`ASWC_ADDR_CTRL1, 8'hb8);
		chk(active_rate_select, 8'h07);
		chk(sleep_rate_select, 8'h02);
		wr(`ASWC_ADDR_INTEN, 8'he1);
		wr(`ASWC_ADDR_WAKE, 8'h42);
		chk(drdy_func_on, 8'h01);
		chk(fifo_func_on, 8'h01);
		event_flags = 11'h0a0;
		tick(3);
		step(4);
		chk(asleep, 8'h00);
		wr(`ASWC_ADDR_CTRL2, 8'h04);
		step(2);
		chk(asleep, 8'h00);
		tick(1);
		pulse(11'h002);
		tick(1);
		step(4);
		chk(asleep, 8'h00);
		pulse(11'h008);
		tick(1);
		step(4);
		chk(asleep, 8'h01);
		chk(drdy_func_on, 8'h00);
		chk(fifo_func_on, 8'h00);
		step(2);
		chk(sleep_irq, 8'h01);
		rd(8'h0b, 8'h02);
		step(2);
		chk(sleep_irq, 8'h00);
		$display("test entry done");
		pulse(11'h049);
		step(2);
		chk(asleep, 8'h01);
		pulse(11'h002);
		chk(asleep, 8'h00);
		chk(drdy_func_on, 8'h00);
		chk(fifo_func_on, 8'h01);
		chk(sleep_irq, 8'h01);
		rd(8'h0b, 8'h01);
		wr(`ASWC_ADDR_INTEN, 8'he1);
		chk(drdy_func_on, 8'h01);
		$display("test wake done");
		wr(`ASWC_ADDR_WAKE, 8'hc0);
		tick(2);
		step(4);
		chk(asleep, 8'h01);
		chk(fifo_block, 8'h01);
		rd(8'h0b, 8'h82);
		step(2);
		chk(fifo_block, 8'h01);
		fifo_empty = 1'h1;
		step(3);
		chk(fifo_block, 8'h00);
		rd(8'h0b, 8'h02);
		$display("test gate done");
		wr(8'h29, 8'h01);
		sleep_at(3'h7, 1'h0, 1);
		sleep_at(3'h6, 1'h0, 2);
		sleep_at(3'h5, 1'h0, 4);
		sleep_at(3'h7, 1'h1, 2);
		sleep_at(3'h6, 1'h1, 4);
		sleep_at(3'h0, 1'h0, 256);
		$display("test step done");
		rd(8'h0b, 8'h02);
		wr(`ASWC_ADDR_INTEN, 8'h61);
		pulse(11'h002);
		step(2);
		chk(asleep, 8'h00);
		chk(sleep_irq, 8'h00);
		chk(fifo_block, 8'h00);
		$display("test enable done");
		conclude;
	end
endmodule
`default_nettype wire
